// ===== design/ccs_defines.vh
// Register map, field positions and reset values of the config block
`ifndef CCS_DEFINES_VH
`define CCS_DEFINES_VH
`define CCS_ADDR_SETUP 8'h1A
`define CCS_ADDR_SCAN 8'h1B
`define CCS_ADDR_RESET 8'h1C
`define CCS_RST_SETUP 16'h2801
`define CCS_RST_SCAN 16'h020F
`define CCS_RST_RESET 16'h0000
`define CCS_SETUP_CHAN_HI 15
`define CCS_SETUP_CHAN_LO 14
`define CCS_SETUP_SLEEP 13
`define CCS_SETUP_OVERRIDE 12
`define CCS_SETUP_ACTMODE 11
`define CCS_SETUP_AMPOFF 10
`define CCS_SETUP_REFSRC 9
`define CCS_SETUP_IRQMASK 7
`define CCS_SETUP_BOOST 6
`define CCS_SCAN_EN 15
`define CCS_SCAN_LIST_HI 14
`define CCS_SCAN_LIST_LO 13
`define CCS_SCAN_GLITCH_HI 2
`define CCS_SCAN_GLITCH_LO 0
`define CCS_RESET_TRIG 15
`define CCS_RESET_GAIN_HI 10
`define CCS_RESET_GAIN_LO 9
`define CCS_LIST_TWO 2'h0
`define CCS_LIST_THREE 2'h1
`define CCS_LIST_FOUR 2'h2
`define CCS_CHAN_LAST2 2'h1
`define CCS_CHAN_LAST3 2'h2
`define CCS_CHAN_LAST4 2'h3
`define CCS_GAIN_X1 2'h0
`define CCS_GAIN_X4 2'h1
`define CCS_GAIN_X8 2'h2
`define CCS_SHIFT_X1 3'h0
`define CCS_SHIFT_X4 3'h2
`define CCS_SHIFT_X8 3'h3
`define CCS_SHIFT_X16 3'h4
`define CCS_GLITCH_1M 3'h1
`define CCS_GLITCH_3M3 3'h4
`define CCS_GLITCH_10M 3'h5
`define CCS_GLITCH_33M 3'h7
`define CCS_BW_1M 2'h0
`define CCS_BW_3M3 2'h1
`define CCS_BW_10M 2'h2
`define CCS_BW_33M 2'h3
`endif

// ===== design/ccs_config_regs.v
// Conversion setup, channel scan and soft reset registers
`timescale 1ns/1ps
`include "ccs_defines.vh"

// How it works
// - Override bit 12 makes conversions use each channel's drive setting; resets 0.
// - Activation bit 11 resets 1; 0 full current, 1 programmed drive.
// - Amplitude-correction-off bit 10 stops correction and freezes initial drive.
// - Mask bit 7 at 0 lets status updates assert the interrupt pin.
// - Boost bit 6 drives channel 0 harder; host avoids it while scanning.
// - Scan bit 15 off converts one channel; on scans the sequence.
// - Sequence 00 and 11 give 0-1, 01 gives 0-2, 10 gives 0-3 when CHAN_COUNT is 4 or more; else all give 0-1.
// - Glitch field picks 1, 3.3, 10 or 33 MHz; reset 111.
// - Writing 1 to reset bit 15 resets the device; reads 0.
// - Gain field 10:9 shifts results by 0, 2, 3 or 4 bits.
// - Without scan, selector bits 15:14 choose converted channel 0 to 3.
// - Sleep bit 13 resets 1 holding sleep; clearing it wakes device.
module ccs_config_regs #(
  parameter CHAN_COUNT = 4
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Register access from the serial bus engine
  input wire regWrEn,
  input wire regRdEn,
  input wire [7:0] regAddr,
  input wire [15:0] regWrData,
  output reg [15:0] regRdData,
  output reg regRdHit,
  // Conversion engine handshake
  input wire convDone,
  input wire statusUpdate,
  input wire [11:0] rawResult,
  // Configuration outputs
  output reg driveOverrideEn,
  output reg activationModeSel,
  output reg ampCorrectionOff,
  output reg refSourceSel,
  output reg boostDriveCh0,
  output reg sleepEn,
  output reg multiChannelScanEn,
  output reg [1:0] activeChan,
  output reg [1:0] glitchBwSel,
  output reg [2:0] gainShift,
  output reg [15:0] scaledResult,
  output reg softResetPulse,
  // Interrupt pin, active low
  output reg irqPinN
);

  reg [15:0] setupQ;
  reg [15:0] scanQ;
  reg [15:0] resetQ;
  reg [1:0] seqChanQ;
  reg [1:0] seqLast;
  reg [2:0] shiftD;
  reg [1:0] bwD;
  reg [1:0] chanD;
  wire trigWrite;

  // A write of 1 to the trigger bit reloads the three config registers and clears the scan position
  assign trigWrite = regWrEn && (regAddr == `CCS_ADDR_RESET) &&
                     regWrData[`CCS_RESET_TRIG];

  // Register file; reserved bits keep whatever was written
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      setupQ <= `CCS_RST_SETUP;
      scanQ <= `CCS_RST_SCAN;
      resetQ <= `CCS_RST_RESET;
    end else if (trigWrite) begin
      setupQ <= `CCS_RST_SETUP;
      scanQ <= `CCS_RST_SCAN;
      resetQ <= `CCS_RST_RESET;
    end else if (regWrEn) begin
      case (regAddr)
        `CCS_ADDR_SETUP: setupQ <= regWrData;
        `CCS_ADDR_SCAN: scanQ <= regWrData;
        `CCS_ADDR_RESET: resetQ <= regWrData;
        default: setupQ <= setupQ;
      endcase
    end
  end

  // Readback; trigger bit never stored so always returns 0
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= 16'h0000;
      regRdHit <= 1'b0;
    end else begin
      regRdHit <= 1'b0;
      if (regRdEn) begin
        case (regAddr)
          `CCS_ADDR_SETUP: begin
            regRdData <= setupQ;
            regRdHit <= 1'b1;
          end
          `CCS_ADDR_SCAN: begin
            regRdData <= scanQ;
            regRdHit <= 1'b1;
          end
          `CCS_ADDR_RESET: begin
            regRdData <= resetQ & ~(16'h0001 << `CCS_RESET_TRIG);
            regRdHit <= 1'b1;
          end
          default: regRdData <= 16'h0000;
        endcase
      end
    end
  end

  // Sequence end channel; 11 aliases 00, small variant caps at two
  always @* begin
    case (scanQ[`CCS_SCAN_LIST_HI:`CCS_SCAN_LIST_LO])
      `CCS_LIST_THREE: seqLast = `CCS_CHAN_LAST3;
      `CCS_LIST_FOUR: seqLast = `CCS_CHAN_LAST4;
      default: seqLast = `CCS_CHAN_LAST2;
    endcase
    if (CHAN_COUNT < 4) begin
      seqLast = `CCS_CHAN_LAST2;
    end
  end

  // Gain field to shift amount
  always @* begin
    case (resetQ[`CCS_RESET_GAIN_HI:`CCS_RESET_GAIN_LO])
      `CCS_GAIN_X1: shiftD = `CCS_SHIFT_X1;
      `CCS_GAIN_X4: shiftD = `CCS_SHIFT_X4;
      `CCS_GAIN_X8: shiftD = `CCS_SHIFT_X8;
      default: shiftD = `CCS_SHIFT_X16;
    endcase
  end

  // Glitch code to bandwidth index; undefined codes fall to widest
  always @* begin
    case (scanQ[`CCS_SCAN_GLITCH_HI:`CCS_SCAN_GLITCH_LO])
      `CCS_GLITCH_1M: bwD = `CCS_BW_1M;
      `CCS_GLITCH_3M3: bwD = `CCS_BW_3M3;
      `CCS_GLITCH_10M: bwD = `CCS_BW_10M;
      default: bwD = `CCS_BW_33M;
    endcase
  end

  // Converted channel: fixed selector or current scan position
  always @* begin
    if (scanQ[`CCS_SCAN_EN]) begin
      chanD = seqChanQ;
    end else begin
      chanD = setupQ[`CCS_SETUP_CHAN_HI:`CCS_SETUP_CHAN_LO];
    end
  end

  // Scan position steps per conversion and wraps to channel 0
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      seqChanQ <= 2'h0;
    end else if (trigWrite || !scanQ[`CCS_SCAN_EN]) begin
      seqChanQ <= 2'h0;
    end else if (convDone) begin
      if (seqChanQ >= seqLast) begin
        seqChanQ <= 2'h0;
      end else begin
        seqChanQ <= seqChanQ + 2'h1;
      end
    end
  end

  // Registered outputs to the converter
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      driveOverrideEn <= 1'b0;
      activationModeSel <= 1'b1;
      ampCorrectionOff <= 1'b0;
      refSourceSel <= 1'b0;
      boostDriveCh0 <= 1'b0;
      sleepEn <= 1'b1;
      multiChannelScanEn <= 1'b0;
      activeChan <= 2'h0;
      glitchBwSel <= `CCS_BW_33M;
      gainShift <= `CCS_SHIFT_X1;
      scaledResult <= 16'h0000;
      softResetPulse <= 1'b0;
      irqPinN <= 1'b1;
    end else begin
      driveOverrideEn <= setupQ[`CCS_SETUP_OVERRIDE];
      activationModeSel <= setupQ[`CCS_SETUP_ACTMODE];
      ampCorrectionOff <= setupQ[`CCS_SETUP_AMPOFF];
      refSourceSel <= setupQ[`CCS_SETUP_REFSRC];
      // Boost is not gated by scan; host keeps the two apart
      boostDriveCh0 <= setupQ[`CCS_SETUP_BOOST];
      sleepEn <= setupQ[`CCS_SETUP_SLEEP];
      multiChannelScanEn <= scanQ[`CCS_SCAN_EN];
      activeChan <= chanD;
      glitchBwSel <= bwD;
      gainShift <= shiftD;
      if (convDone) begin
        scaledResult <= {4'h0, rawResult} << shiftD;
      end
      softResetPulse <= trigWrite;
      // Low for one cycle per status update unless masked
      irqPinN <= ~(statusUpdate && !setupQ[`CCS_SETUP_IRQMASK]);
    end
  end

endmodule

// ===== verif/ccs_config_chk.sv
// Assertion checker for the config register block
`timescale 1ns/1ps
module ccs_config_chk (
  // Clock, reset and register bus
  input wire core_clk,
  input wire rst_b,
  input wire regWrEn,
  input wire regRdEn,
  input wire [7:0] regAddr,
  input wire [15:0] regWrData,
  input wire [15:0] regRdData,
  input wire regRdHit,
  // Engine pulses and config outputs
  input wire convDone,
  input wire statusUpdate,
  input wire driveOverrideEn,
  input wire sleepEn,
  input wire multiChannelScanEn,
  input wire [1:0] activeChan,
  input wire [1:0] glitchBwSel,
  input wire [2:0] gainShift,
  input wire softResetPulse,
  input wire irqPinN
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Code 0 is the only gain code off the plus-one line
  wire [2:0] expSh = regWrData[10:9] == 2'h0 ? 3'h0 : regWrData[10:9] + 3'h1;
  // Soft reset is a write and then a single pulse
  sequence rstWr;
    regWrEn && regAddr == 8'h1C && regWrData[15];
  endsequence
  sequence onePulse;
    softResetPulse ##1 !softResetPulse;
  endsequence
  rst_pulse_a: assert property (rstWr |=> onePulse)
    else $error("bad reset pulse");
  rst_vals_a: assert property (softResetPulse |=> sleepEn)
    else $error("sleep not restored");
  rd_zero_a: assert property (regRdEn && regAddr == 8'h1C |=>
    regRdHit && !regRdData[15]) else $error("trigger reads high");
  ovr_a: assert property (regWrEn && regAddr == 8'h1A |-> ##2
    driveOverrideEn == $past(regWrData[12], 2)) else $error("bad override");
  irq_a: assert property ($fell(irqPinN) |-> $past(statusUpdate))
    else $error("stray irq");
  gain_a: assert property (regWrEn && regAddr == 8'h1C && !regWrData[15]
    |-> ##2 gainShift == $past(expSh, 2)) else $error("bad gain");
  glitch_a: assert property (regWrEn && regAddr == 8'h1B
    && regWrData[2:0] == 3'h4 |-> ##2 glitchBwSel == 2'h1)
    else $error("bad glitch code");
  // Only a scan wraps; a fixed selector of 3 legally stays at 3
  wrap_a: assert property (convDone && multiChannelScanEn
    && activeChan == 2'h3
    |-> ##2 activeChan != 2'h3) else $error("no wrap");
endmodule
bind ccs_config_regs ccs_config_chk ccs_config_chk_i (.core_clk, .rst_b,
  .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .regRdHit,
  .convDone, .statusUpdate, .driveOverrideEn, .sleepEn,
  .multiChannelScanEn, .activeChan,
  .glitchBwSel, .gainShift, .softResetPulse, .irqPinN);

// ===== verif/ccs_host_model.sv
// Host model issuing register strobes to the config block
`timescale 1ns/1ps
module ccs_host_model (
  // Clock and read return
  input wire core_clk,
  input wire [15:0] regRdData,
  input wire regRdHit,
  // Strobes toward the block
  output logic regWrEn = 1'b0,
  output logic regRdEn = 1'b0,
  output logic [7:0] regAddr = 8'h00,
  output logic [15:0] regWrData = 16'h0000
);
  // Released fields show the inverse so stale values are never trusted
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrEn <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdHit ? regRdData : 16'hDEAD;
  endtask
endmodule

// ===== verif/ccs_config_regs_tb.sv
// Self-checking bench for the config register block
`timescale 1ns/1ps
module ccs_config_regs_tb;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic convDone = 1'b0;
  logic statusUpdate = 1'b0;
  logic [11:0] rawResult = 12'hA5C;
  logic [15:0] rv;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  wire regWrEn, regRdEn, regRdHit, driveOverrideEn, activationModeSel;
  wire ampCorrectionOff, refSourceSel, boostDriveCh0, sleepEn, irqPinN;
  wire multiChannelScanEn, softResetPulse;
  wire [7:0] regAddr;
  wire [15:0] regWrData, regRdData, scaledResult;
  wire [1:0] activeChan, glitchBwSel;
  wire [2:0] gainShift;
  ccs_config_regs ccs_config_regs_i (.core_clk, .rst_b, .regWrEn, .regRdEn,
    .regAddr, .regWrData, .regRdData, .regRdHit, .convDone, .statusUpdate,
    .rawResult, .driveOverrideEn, .activationModeSel, .ampCorrectionOff,
    .refSourceSel, .boostDriveCh0, .sleepEn, .multiChannelScanEn,
    .activeChan, .glitchBwSel, .gainShift, .scaledResult, .softResetPulse,
    .irqPinN);
  ccs_host_model ccs_host_model_i (.core_clk, .regRdData, .regRdHit,
    .regWrEn, .regRdEn, .regAddr, .regWrData);
  always #10 core_clk = ~core_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    ccs_host_model_i.rd(a, rv);
    chk(rv, exp);
  endtask
  // One engine pulse; a conversion pulse then waits until the scan position has moved
  task automatic pulse(input logic conv);
    @(posedge core_clk);
    convDone <= conv;
    statusUpdate <= !conv;
    @(posedge core_clk);
    convDone <= 1'b0;
    statusUpdate <= 1'b0;
    #1;
    if (conv) @(posedge core_clk);
    #1;
  endtask
  task automatic t_setup;
    ccs_host_model_i.wr(8'h1A, 16'h5EC1);
    pulse(1'b0);
    chk({8'h00, activeChan, sleepEn, driveOverrideEn, activationModeSel,
      ampCorrectionOff, refSourceSel, boostDriveCh0}, 16'h005F);
    chk({15'h0, irqPinN}, 16'h0001);
    rdc(8'h1A, 16'h5EC1);
    ccs_host_model_i.wr(8'h1A, 16'h1E01);
    pulse(1'b0);
    chk({15'h0, irqPinN}, 16'h0000);
  endtask
  // Every sequence code with one glitch code each, wrapping twice for the two-channel codes, once otherwise
  task automatic t_scan;
    logic [2:0] gl [4] = '{3'h1, 3'h4, 3'h5, 3'h7};
    int n;
    for (int c = 0; c < 4; c++) begin
      n = c == 1 ? 3 : c == 2 ? 4 : 2;
      ccs_host_model_i.wr(8'h1B, 16'h020F);
      ccs_host_model_i.wr(8'h1B, {1'b1, c[1:0], 13'h0208} | gl[c]);
      // Outputs follow the stored field one edge later
      @(posedge core_clk);
      #1;
      chk({14'h0, glitchBwSel}, c[15:0]);
      chk({15'h0, multiChannelScanEn}, 16'h0001);
      for (int i = 1; i <= 4; i++) begin
        pulse(1'b1);
        chk({14'h0, activeChan}, 16'(i % n));
      end
    end
    ccs_host_model_i.wr(8'h1B, 16'h020F);
    @(posedge core_clk);
    #1;
    chk({15'h0, multiChannelScanEn}, 16'h0000);
  endtask
  task automatic t_gain;
    int sh [4] = '{0, 2, 3, 4};
    for (int k = 0; k < 4; k++) begin
      ccs_host_model_i.wr(8'h1C, {5'h00, k[1:0], 9'h000});
      pulse(1'b1);
      chk(scaledResult, 16'h0A5C << sh[k]);
    end
    rdc(8'h1C, 16'h0600);
    rdc(8'h1D, 16'hDEAD);
  endtask
  task automatic complete_run;
    $display("mismatches %0d of %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Ceiling far above the roughly 120 cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      complete_run;
    end
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    rdc(8'h1B, 16'h020F);
    t_setup;
    t_scan;
    t_gain;
    ccs_host_model_i.wr(8'h1C, 16'h8600);
    rdc(8'h1A, 16'h2801);
    rdc(8'h1C, 16'h0000);
    complete_run;
  end
endmodule
